// >>> hdl/sfp_front.v
// serial flash command front end with sector protection and password unlock
`timescale 1ns/100ps
`default_nettype none
`include "sfp_regs.vh"

// Functional notes
// [R01] a group is unprotected only when its persistent and dynamic bits are both one
// [R02] dynamic bits return to unprotected on power-up, hardware or software reset
// [R03] persistent bits cannot change while the lock bit is zero; dynamic bits always can
// [R04] persistent mode: lock bit set at power-up and hardware reset, kept by software reset
// [R05] clear-lock command clears the lock bit; nothing sets it again until reset
// [R06] password mode: lock bit cleared at reset, set only by a correct 64-bit unlock
// [R07] password has its own storage, program and read commands, factory value all ones
// [R08] password program and read are ignored once the region lock is programmed
// [R09] password programming only clears bits; a one over a zero stays zero, no error
// [R10] wrong password sets program and protection error flags, lock bit stays zero
// [R11] failed unlock keeps write-in-progress high about 100 us; correct one adds no delay
// [R12] 8-bit instruction, msb first bits, msb first address bytes, incrementing data bytes
// [R13] inputs sampled on rising clock edge, on both edges in double-rate mode
// [R14] each command is an instruction byte, then 24 or 32 bit address, dummy, data
// [R15] the instruction chooses one, two or four bits per address and data transfer
// [R16] continuation mode bits let the next command skip its instruction byte
// [R17] while busy, array reads and most commands are ignored
// [R18] the host should poll write-in-progress before issuing commands while busy
// [R19] host drives select, clock and input; device drives output and shares quad lines
// [R20] select low frames a command; rising off a byte boundary rejects it; page program has already written each complete byte
// [R21] extended bit or 4-byte mode makes standard instructions take a 32-bit address
// [R22] in 3-byte addressing the bank register gives the high address byte, reset bank 0
// [R23] reads stream across banks to array end; bank register never updated by a read
// [R24] persistent bits program to zero singly and erase to one all together
// [R25] program or erase to a protected group leaves the array and sets both error flags
module sfp_front (
  input wire ref_clk,
  input wire rst,
  input wire chipEnN,
  input wire serialClk,
  input wire [3:0] ioIn,
  output reg [3:0] ioOut,
  output reg [3:0] ioOe,
  input wire passwordModeSel,
  input wire pwdRegionLockN,
  input wire [3:0] dummyCycles,
  input wire arrBusy,
  input wire [7:0] arrRdData,
  output reg [31:0] arrAddr,
  output reg [7:0] arrWrData,
  output reg arrWrStb,
  output reg arrEraseStb,
  output reg [7:0] arrEraseOp,
  output reg writeInProgress,
  output reg programErrorFlag,
  output reg protectionErrorFlag,
  output reg persistentLockBit,
  output reg addr4Mode
);

  localparam [2:0] ST_IDLE = 3'd0, ST_INST = 3'd1, ST_ADDR = 3'd2, ST_DUMMY = 3'd3;
  localparam [2:0] ST_IN = 3'd4, ST_OUT = 3'd5, ST_IGN = 3'd6;
  localparam [4:0] K_NONE = 5'd0, K_READ = 5'd1, K_FREAD = 5'd2, K_PROG = 5'd3, K_ERASE = 5'd4;
  localparam [4:0] K_RDDYB = 5'd5, K_WRDYB = 5'd6, K_RDPPB = 5'd7, K_PGPPB = 5'd8, K_ERPPB = 5'd9;
  localparam [4:0] K_CLRLOCK = 5'd10, K_UNLOCK = 5'd11, K_PGPWD = 5'd12, K_RDPWD = 5'd13;
  localparam [4:0] K_EN4B = 5'd14, K_EX4B = 5'd15, K_WRBANK = 5'd16, K_RDSR = 5'd17, K_CLSR = 5'd18, K_SRST = 5'd19;
  localparam [31:0] THR_CYC = `SFP_UNLOCK_WAIT_CYC;

  reg [5:0] pinS1_q, pinS2_q, pinS3_q, pinF_q, pinP_q;
  reg [2:0] state_q;
  reg [4:0] opKind_q;
  reg [7:0] opcode_q;
  reg [2:0] opBwA_q, opBwD_q;
  reg opDtr_q, addr32_q, cont_q, modeCont_q, mode4_q;
  reg [31:0] sh_q;
  reg [6:0] cnt_q;
  reg [2:0] tot_q;
  reg [3:0] dum_q, byteCnt_q, outCnt_q;
  reg [7:0] outSh_q, dat_q, bank_q;
  reg [63:0] pwd_q, pwdBuf_q;
  reg [`SFP_GROUPS-1:0] ppb_q, dyb_q;
  reg [11:0] thrCnt_q;

  // a pin bit moves only once the second and third stages agree
  wire [5:0] pinAgree = ~(pinS2_q ^ pinS3_q);
  wire [5:0] pinNext = (pinAgree & pinS2_q) | (~pinAgree & pinF_q);
  wire sckRise = pinF_q[`SFP_PIN_SCK] & ~pinP_q[`SFP_PIN_SCK];
  wire sckFall = ~pinF_q[`SFP_PIN_SCK] & pinP_q[`SFP_PIN_SCK];
  wire csRise = pinF_q[`SFP_PIN_CS] & ~pinP_q[`SFP_PIN_CS];
  wire csFall = ~pinF_q[`SFP_PIN_CS] & pinP_q[`SFP_PIN_CS];
  wire [3:0] ioS = pinF_q[3:0];
  wire sampleEdge = sckRise | (opDtr_q & sckFall); // [R13]
  wire driveEdge = sckFall | (opDtr_q & sckRise);
  wire [8:0] grp = arrAddr[`SFP_GROUP_MSB:`SFP_GROUP_LSB];
  wire unprot = ppb_q[grp] & dyb_q[grp]; // [R01]
  wire [2:0] bwCur = (state_q == ST_IN || state_q == ST_OUT) ? opBwD_q : opBwA_q; // [R15]
  wire [6:0] cntNew = cnt_q + {4'h0, bwCur};
  wire [6:0] addrBits = addr32_q ? 7'd32 : 7'd24;

  reg [31:0] shNew;
  always @* begin
    case (bwCur)
      3'd4: shNew = {sh_q[27:0], ioS};
      3'd2: shNew = {sh_q[29:0], ioS[1:0]};
      default: shNew = {sh_q[30:0], ioS[0]}; // [R12]
    endcase
  end

  reg [4:0] dKind;
  reg [2:0] dBwA, dBwD;
  reg d4B, dDtr;
  always @* begin
    dKind = K_NONE;
    dBwA = 3'd1;
    dBwD = 3'd1;
    d4B = 1'b0;
    dDtr = 1'b0;
    case (shNew[7:0])
      `SFP_OP_READ4, `SFP_OP_FRD4, `SFP_OP_FRDO4, `SFP_OP_FRDIO4, `SFP_OP_FRQO4, `SFP_OP_FRQIO4,
      `SFP_OP_FRDTR4, `SFP_OP_FRQDTR4, `SFP_OP_PP4, `SFP_OP_PPQ4, `SFP_OP_SER4, `SFP_OP_BER32_4,
      `SFP_OP_BER64_4, `SFP_OP_RDDYB4, `SFP_OP_WRDYB4, `SFP_OP_RDPPB4, `SFP_OP_PGPPB4: d4B = 1'b1;
      default: d4B = 1'b0;
    endcase
    case (shNew[7:0])
      `SFP_OP_READ, `SFP_OP_READ4: dKind = K_READ;
      `SFP_OP_FRD, `SFP_OP_FRD4: dKind = K_FREAD;
      `SFP_OP_FRDO, `SFP_OP_FRDO4: begin
        dKind = K_FREAD;
        dBwD = 3'd2;
      end
      `SFP_OP_FRDIO, `SFP_OP_FRDIO4: begin
        dKind = K_FREAD;
        dBwA = 3'd2;
        dBwD = 3'd2;
      end
      `SFP_OP_FRQO, `SFP_OP_FRQO4: begin
        dKind = K_FREAD;
        dBwD = 3'd4;
      end
      `SFP_OP_FRQIO, `SFP_OP_FRQIO4: begin
        dKind = K_FREAD;
        dBwA = 3'd4;
        dBwD = 3'd4;
      end
      `SFP_OP_FRDTR, `SFP_OP_FRDTR4: begin
        dKind = K_FREAD;
        dDtr = 1'b1;
      end
      `SFP_OP_FRQDTR, `SFP_OP_FRQDTR4: begin
        dKind = K_FREAD;
        dBwA = 3'd4;
        dBwD = 3'd4;
        dDtr = 1'b1;
      end
      `SFP_OP_PP, `SFP_OP_PP4: dKind = K_PROG;
      `SFP_OP_PPQ, `SFP_OP_PPQ4: begin
        dKind = K_PROG;
        dBwD = 3'd4;
      end
      `SFP_OP_SER, `SFP_OP_SERA, `SFP_OP_SER4, `SFP_OP_BER32, `SFP_OP_BER32_4, `SFP_OP_BER64,
      `SFP_OP_BER64_4: dKind = K_ERASE;
      `SFP_OP_RDDYB, `SFP_OP_RDDYB4: dKind = K_RDDYB;
      `SFP_OP_WRDYB, `SFP_OP_WRDYB4: dKind = K_WRDYB;
      `SFP_OP_RDPPB, `SFP_OP_RDPPB4: dKind = K_RDPPB;
      `SFP_OP_PGPPB, `SFP_OP_PGPPB4: dKind = K_PGPPB;
      `SFP_OP_ERPPB: dKind = K_ERPPB;
      `SFP_OP_CLRLOCK: dKind = K_CLRLOCK;
      `SFP_OP_UNLOCK: dKind = K_UNLOCK;
      `SFP_OP_PGPWD: dKind = K_PGPWD;
      `SFP_OP_RDPWD: dKind = K_RDPWD;
      `SFP_OP_EN4B: dKind = K_EN4B;
      `SFP_OP_EX4B: dKind = K_EX4B;
      `SFP_OP_WRBANK: dKind = K_WRBANK;
      `SFP_OP_RDSR: dKind = K_RDSR;
      `SFP_OP_CLSR: dKind = K_CLSR;
      `SFP_OP_SRST: dKind = K_SRST;
      default: dKind = K_NONE;
    endcase
    // status read stays available while busy so the host can poll
    if (writeInProgress && dKind != K_RDSR) // [R17] [R18]
      dKind = K_NONE;
    if (!pwdRegionLockN && (dKind == K_PGPWD || dKind == K_RDPWD)) // [R08]
      dKind = K_NONE;
  end

  reg [7:0] srcByte, outByte;
  reg [3:0] outNib, oeMask;
  always @* begin
    case (opKind_q)
      K_RDDYB: srcByte = {8{dyb_q[grp]}};
      K_RDPPB: srcByte = {8{ppb_q[grp]}};
      K_RDPWD: srcByte = pwd_q[{byteCnt_q[2:0], 3'b000} +: 8]; // [R07]
      K_RDSR: srcByte = {5'h00, protectionErrorFlag, programErrorFlag, writeInProgress};
      default: srcByte = arrRdData;
    endcase
    outByte = (outCnt_q == 4'h0) ? srcByte : outSh_q;
    // single-bit reads leave on the output line, io1 [R19]
    case (opBwD_q)
      3'd4: begin
        outNib = outByte[7:4];
        oeMask = 4'hf;
      end
      3'd2: begin
        outNib = {2'b00, outByte[7:6]};
        oeMask = 4'h3;
      end
      default: begin
        outNib = {2'b00, outByte[7], 1'b0};
        oeMask = 4'h2;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      pinS1_q <= `SFP_PIN_IDLE;
      pinS2_q <= `SFP_PIN_IDLE;
      pinS3_q <= `SFP_PIN_IDLE;
      pinF_q <= `SFP_PIN_IDLE;
      pinP_q <= `SFP_PIN_IDLE;
      state_q <= ST_IDLE;
      opKind_q <= K_NONE;
      opcode_q <= 8'h00;
      opBwA_q <= 3'd1;
      opBwD_q <= 3'd1;
      opDtr_q <= 1'b0;
      addr32_q <= 1'b0;
      cont_q <= 1'b0;
      modeCont_q <= 1'b0;
      mode4_q <= 1'b0;
      sh_q <= 32'h0000_0000;
      cnt_q <= 7'h00;
      tot_q <= 3'h0;
      dum_q <= 4'h0;
      byteCnt_q <= 4'h0;
      outCnt_q <= 4'h0;
      outSh_q <= 8'h00;
      dat_q <= 8'h00;
      bank_q <= `SFP_BANK_RST; // [R22]
      pwd_q <= `SFP_PWD_RST; // [R07]
      pwdBuf_q <= 64'h0000_0000_0000_0000;
      ppb_q <= {`SFP_GROUPS{1'b1}};
      dyb_q <= {`SFP_GROUPS{1'b1}}; // [R02]
      thrCnt_q <= 12'h000;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      arrAddr <= 32'h0000_0000;
      arrWrData <= 8'h00;
      arrWrStb <= 1'b0;
      arrEraseStb <= 1'b0;
      arrEraseOp <= 8'h00;
      writeInProgress <= 1'b0;
      programErrorFlag <= 1'b0;
      protectionErrorFlag <= 1'b0;
      persistentLockBit <= ~passwordModeSel; // [R04] [R06]
      addr4Mode <= 1'b0;
    end else begin
      pinS1_q <= {chipEnN, serialClk, ioIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= pinNext;
      pinP_q <= pinF_q;
      arrWrStb <= 1'b0;
      arrEraseStb <= 1'b0;
      if (arrWrStb)
        arrAddr <= arrAddr + 32'h1; // [R12]
      if (thrCnt_q != 12'h000)
        thrCnt_q <= thrCnt_q - 12'h001;
      writeInProgress <= arrBusy | (thrCnt_q != 12'h000); // [R11]
      addr4Mode <= bank_q[`SFP_BANK_EXT_BIT] | mode4_q;
      if (csFall) begin
        cnt_q <= 7'h00;
        tot_q <= 3'h0;
        dum_q <= 4'h0;
        byteCnt_q <= 4'h0;
        outCnt_q <= 4'h0;
        modeCont_q <= 1'b0;
        if (cont_q) begin
          state_q <= ST_ADDR; // [R16]
        end else begin
          state_q <= ST_INST;
          opKind_q <= K_NONE;
          opBwA_q <= 3'd1;
          opDtr_q <= 1'b0;
        end
      end else if (csRise) begin
        state_q <= ST_IDLE;
        ioOe <= 4'h0;
        cont_q <= modeCont_q;
        // anything that acts on the whole frame runs only on a clean byte boundary
        if (tot_q == 3'h0) begin // [R20]
          case (opKind_q)
            K_ERASE: begin
              if (unprot) begin
                arrEraseStb <= 1'b1;
                arrEraseOp <= opcode_q;
              end else begin
                programErrorFlag <= 1'b1; // [R25]
                protectionErrorFlag <= 1'b1;
              end
            end
            K_WRDYB: if (byteCnt_q != 4'h0) dyb_q[grp] <= (dat_q == 8'hff); // [R03]
            K_PGPPB: begin
              if (persistentLockBit) begin
                ppb_q[grp] <= 1'b0; // [R24]
              end else begin
                programErrorFlag <= 1'b1; // [R03]
                protectionErrorFlag <= 1'b1;
              end
            end
            K_ERPPB: begin
              if (persistentLockBit) begin
                ppb_q <= {`SFP_GROUPS{1'b1}}; // [R24]
              end else begin
                programErrorFlag <= 1'b1; // [R03]
                protectionErrorFlag <= 1'b1;
              end
            end
            K_CLRLOCK: persistentLockBit <= 1'b0; // [R05]
            K_UNLOCK: begin
              if (passwordModeSel && byteCnt_q == `SFP_PWD_BYTES) begin
                if (pwdBuf_q == pwd_q) begin
                  persistentLockBit <= 1'b1; // [R06]
                end else begin
                  programErrorFlag <= 1'b1; // [R10]
                  protectionErrorFlag <= 1'b1;
                  thrCnt_q <= THR_CYC[11:0]; // [R11]
                end
              end
            end
            K_EN4B: mode4_q <= 1'b1; // [R21]
            K_EX4B: mode4_q <= 1'b0;
            K_WRBANK: if (byteCnt_q != 4'h0) bank_q <= dat_q;
            K_CLSR: begin
              programErrorFlag <= 1'b0;
              protectionErrorFlag <= 1'b0;
            end
            K_SRST: begin
              dyb_q <= {`SFP_GROUPS{1'b1}}; // [R02]
              bank_q <= `SFP_BANK_RST;
              mode4_q <= 1'b0;
            end
            default: ;
          endcase
        end
      end else if (!pinF_q[`SFP_PIN_CS]) begin
        case (state_q)
          ST_INST: if (sckRise) begin
            sh_q <= shNew;
            cnt_q <= cntNew;
            tot_q <= tot_q + 3'd1;
            if (cntNew == 7'd8) begin // [R14]
              cnt_q <= 7'h00;
              opcode_q <= shNew[7:0];
              opKind_q <= dKind;
              opBwA_q <= dBwA;
              opBwD_q <= dBwD;
              opDtr_q <= dDtr;
              addr32_q <= d4B | bank_q[`SFP_BANK_EXT_BIT] | mode4_q; // [R21]
              case (dKind)
                K_READ, K_FREAD, K_PROG, K_ERASE, K_RDDYB, K_WRDYB, K_RDPPB, K_PGPPB: state_q <= ST_ADDR;
                K_RDSR, K_RDPWD: state_q <= ST_OUT;
                K_WRBANK, K_UNLOCK, K_PGPWD: state_q <= ST_IN;
                default: state_q <= ST_IGN;
              endcase
            end
          end
          ST_ADDR: if (sampleEdge) begin
            sh_q <= shNew;
            cnt_q <= cntNew;
            tot_q <= tot_q + bwCur;
            if (cntNew == addrBits) begin
              cnt_q <= 7'h00;
              arrAddr <= addr32_q ? shNew : {bank_q & `SFP_BANK_SEL_MASK, shNew[23:0]}; // [R22]
              case (opKind_q)
                K_FREAD: state_q <= (dummyCycles == 4'h0) ? ST_OUT : ST_DUMMY;
                K_READ, K_RDDYB, K_RDPPB: state_q <= ST_OUT;
                K_PROG, K_WRDYB: state_q <= ST_IN;
                default: state_q <= ST_IGN;
              endcase
            end
          end
          ST_DUMMY: if (sckRise) begin
            sh_q <= shNew;
            cnt_q <= cntNew;
            dum_q <= dum_q + 4'h1;
            // mode bits are the first dummy byte and count toward the dummy cycles
            if (cntNew == 7'd8)
              modeCont_q <= (opBwA_q == 3'd4) && (shNew[7:4] == `SFP_CONT_MODE); // [R16]
            if (dum_q + 4'h1 == dummyCycles)
              state_q <= ST_OUT;
          end
          ST_IN: if (sampleEdge) begin
            sh_q <= shNew;
            cnt_q <= cntNew;
            tot_q <= tot_q + bwCur;
            if (cntNew[2:0] == 3'h0) begin
              cnt_q <= 7'h00;
              if (byteCnt_q != 4'hf)
                byteCnt_q <= byteCnt_q + 4'h1;
              case (opKind_q)
                K_PROG: begin
                  // each byte goes out as soon as complete; a trailing partial byte is dropped
                  if (unprot) begin
                    arrWrData <= shNew[7:0];
                    arrWrStb <= 1'b1;
                  end else begin
                    programErrorFlag <= 1'b1; // [R25]
                    protectionErrorFlag <= 1'b1;
                  end
                end
                K_WRDYB, K_WRBANK: dat_q <= shNew[7:0];
                K_UNLOCK: pwdBuf_q <= {shNew[7:0], pwdBuf_q[63:8]};
                K_PGPWD: if (byteCnt_q < `SFP_PWD_BYTES)
                  pwd_q[{byteCnt_q[2:0], 3'b000} +: 8] <= pwd_q[{byteCnt_q[2:0], 3'b000} +: 8] & shNew[7:0]; // [R09]
                default: ;
              endcase
            end
          end
          ST_OUT: if (driveEdge) begin
            ioOut <= outNib;
            ioOe <= oeMask; // [R19]
            outSh_q <= outByte << bwCur;
            outCnt_q <= ((outCnt_q == 4'h0) ? 4'h8 : outCnt_q) - {1'b0, bwCur};
            if (outCnt_q == 4'h0) begin
              byteCnt_q <= byteCnt_q + 4'h1;
              // reads walk straight across banks; the bank register is left alone
              if (opKind_q == K_READ || opKind_q == K_FREAD)
                arrAddr <= arrAddr + 32'h1; // [R23]
            end
          end
          ST_IGN: if (sampleEdge) tot_q <= tot_q + bwCur; // [R20]
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> shared/sfp_regs.vh
// constants for the serial flash protection and command front end
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// timing
`define SFP_CLK_PERIOD_NS 50
`define SFP_UNLOCK_WAIT_NS 100000
`define SFP_UNLOCK_WAIT_CYC (`SFP_UNLOCK_WAIT_NS / `SFP_CLK_PERIOD_NS)

// synchroniser bit positions and idle value
`define SFP_PIN_CS 5
`define SFP_PIN_SCK 4
`define SFP_PIN_IDLE 6'h20

// protection storage
`define SFP_GROUPS 512
`define SFP_GROUP_LSB 16
`define SFP_GROUP_MSB 24
`define SFP_PWD_RST 64'hffff_ffff_ffff_ffff
`define SFP_PWD_BYTES 4'h8

// bank register fields
`define SFP_BANK_EXT_BIT 7
`define SFP_BANK_RST 8'h00
`define SFP_BANK_SEL_MASK 8'h7f

// status byte fields
`define SFP_STAT_WIP 0
`define SFP_STAT_PERR 1
`define SFP_STAT_PROTE 2

// continuation mode nibble
`define SFP_CONT_MODE 4'ha

// opcodes
`define SFP_OP_READ 8'h03
`define SFP_OP_READ4 8'h13
`define SFP_OP_FRD 8'h0b
`define SFP_OP_FRD4 8'h0c
`define SFP_OP_FRDO 8'h3b
`define SFP_OP_FRDO4 8'h3c
`define SFP_OP_FRDIO 8'hbb
`define SFP_OP_FRDIO4 8'hbc
`define SFP_OP_FRQO 8'h6b
`define SFP_OP_FRQO4 8'h6c
`define SFP_OP_FRQIO 8'heb
`define SFP_OP_FRQIO4 8'hec
`define SFP_OP_FRDTR 8'h0d
`define SFP_OP_FRDTR4 8'h0e
`define SFP_OP_FRQDTR 8'hed
`define SFP_OP_FRQDTR4 8'hee
`define SFP_OP_PP 8'h02
`define SFP_OP_PP4 8'h12
`define SFP_OP_PPQ 8'h32
`define SFP_OP_PPQ4 8'h34
`define SFP_OP_SER 8'h20
`define SFP_OP_SERA 8'hd7
`define SFP_OP_SER4 8'h21
`define SFP_OP_BER32 8'h52
`define SFP_OP_BER32_4 8'h5c
`define SFP_OP_BER64 8'hd8
`define SFP_OP_BER64_4 8'hdc
`define SFP_OP_RDDYB 8'hfa
`define SFP_OP_RDDYB4 8'he0
`define SFP_OP_WRDYB 8'hfb
`define SFP_OP_WRDYB4 8'he1
`define SFP_OP_RDPPB 8'hfc
`define SFP_OP_RDPPB4 8'he2
`define SFP_OP_PGPPB 8'hfd
`define SFP_OP_PGPPB4 8'he3
`define SFP_OP_ERPPB 8'he4
`define SFP_OP_CLRLOCK 8'ha6
`define SFP_OP_UNLOCK 8'he9
`define SFP_OP_PGPWD 8'he8
`define SFP_OP_RDPWD 8'he7
`define SFP_OP_EN4B 8'hb7
`define SFP_OP_EX4B 8'h29
`define SFP_OP_WRBANK 8'h17
`define SFP_OP_RDSR 8'h05
`define SFP_OP_CLSR 8'h30
`define SFP_OP_SRST 8'h99

`endif

// >>> bench/sfp_front_chk.sv
// port assertions for the flash protection and command front end
`timescale 1ns/100ps
`default_nettype none
module sfp_front_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chipEnN,
  input wire logic passwordModeSel,
  input wire logic arrBusy,
  input wire logic [3:0] ioOe,
  input wire logic [31:0] arrAddr,
  input wire logic arrWrStb,
  input wire logic arrEraseStb,
  input wire logic writeInProgress,
  input wire logic programErrorFlag,
  input wire logic protectionErrorFlag,
  input wire logic persistentLockBit,
  input wire logic addr4Mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [11:0] wipCnt_q;
  // counts throttle time only; array busy time is unbounded by design
  always_ff @(posedge ref_clk) begin
    if (rst || !writeInProgress || arrBusy) wipCnt_q <= 12'h000;
    else if (wipCnt_q != 12'hfff) wipCnt_q <= wipCnt_q + 12'h001;
  end
  a_oe_idle: assert property (chipEnN [*6] |-> ioOe == 4'h0)
    else $error("outputs enabled while deselected");
  a_oe_legal: assert property (ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'h3 || ioOe == 4'hf)
    else $error("illegal enable pattern");
  a_lock_reset: assert property (disable iff (1'b0) rst |=> persistentLockBit == !$past(passwordModeSel))
    else $error("lock bit wrong after reset");
  a_lock_stays: assert property (!passwordModeSel && !persistentLockBit |=> !persistentLockBit)
    else $error("lock bit set again without reset");
  a_wip_busy: assert property (arrBusy |=> writeInProgress)
    else $error("busy not shown");
  a_err_pair: assert property ($rose(protectionErrorFlag) |-> programErrorFlag)
    else $error("protection error without program error");
  a_throttle_max: assert property (wipCnt_q <= 12'h960)
    else $error("throttle too long");
  a_throttle_min: assert property ($rose(protectionErrorFlag) && passwordModeSel |-> ##[0:4] writeInProgress [*8])
    else $error("throttle missing");
  a_wr_incr: assert property (arrWrStb |=> !arrWrStb && arrAddr == $past(arrAddr) + 32'h1)
    else $error("program address did not increment");
  a_erase_frame: assert property (arrEraseStb |-> chipEnN && $past(chipEnN, 4))
    else $error("erase before frame end");
  a_addr4_frame: assert property ($changed(addr4Mode) |-> $past(chipEnN, 3))
    else $error("address mode changed inside frame");
endmodule
bind sfp_front sfp_front_chk u_chk (.ref_clk(ref_clk), .rst(rst), .chipEnN(chipEnN),
  .passwordModeSel(passwordModeSel), .arrBusy(arrBusy), .ioOe(ioOe), .arrAddr(arrAddr), .arrWrStb(arrWrStb),
  .arrEraseStb(arrEraseStb), .writeInProgress(writeInProgress), .programErrorFlag(programErrorFlag),
  .protectionErrorFlag(protectionErrorFlag), .persistentLockBit(persistentLockBit), .addr4Mode(addr4Mode));
`default_nettype wire

// >>> bench/sfp_host.sv
// host controller model driving select, serial clock and the input line
`timescale 1ns/100ps
`default_nettype none
module sfp_host (
  input wire logic ref_clk,
  output logic chipEnN,
  output logic serialClk,
  output logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  initial begin
    chipEnN = 1'b1;
    serialClk = 1'b0;
    ioIn = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [127:0] tx, input int nbits, output logic [127:0] rx);
    rx = '0;
    chipEnN <= 1'b0;
    tick(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      ioIn[0] <= tx[i];
      tick(4);
      serialClk <= 1'b1;
      tick(4);
      rx = {rx[126:0], ioOe[1] ? ioOut[1] : ~rx[0]};
      serialClk <= 1'b0;
    end
    tick(4);
    chipEnN <= 1'b1;
    ioIn <= ~ioIn;
    tick(8);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the flash protection and command front end
`timescale 1ns/100ps
`default_nettype none
`include "sfp_regs.vh"
module tb_top;
  logic ref_clk, rst, chipEnN, serialClk, passwordModeSel, pwdRegionLockN, arrBusy, arrWrStb, arrEraseStb;
  logic writeInProgress, programErrorFlag, protectionErrorFlag, persistentLockBit, addr4Mode, oeSeen;
  logic [3:0] ioIn, ioOut, ioOe, dummyCycles;
  logic [7:0] arrRdData, arrWrData, arrEraseOp, wrByte;
  logic [31:0] arrAddr, wrAddr;
  logic [127:0] rx;
  logic [63:0] pwd;
  int errors, n_compared, cycles, wrCount, erCount;
  sfp_front u_dut (.ref_clk(ref_clk), .rst(rst), .chipEnN(chipEnN), .serialClk(serialClk), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .passwordModeSel(passwordModeSel), .pwdRegionLockN(pwdRegionLockN),
    .dummyCycles(dummyCycles), .arrBusy(arrBusy), .arrRdData(arrRdData), .arrAddr(arrAddr),
    .arrWrData(arrWrData), .arrWrStb(arrWrStb), .arrEraseStb(arrEraseStb), .arrEraseOp(arrEraseOp),
    .writeInProgress(writeInProgress), .programErrorFlag(programErrorFlag),
    .protectionErrorFlag(protectionErrorFlag), .persistentLockBit(persistentLockBit), .addr4Mode(addr4Mode));
  sfp_host u_host (.ref_clk(ref_clk), .chipEnN(chipEnN), .serialClk(serialClk), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    arrRdData <= arrAddr[7:0] ^ 8'h5a;
    if (arrWrStb === 1'b1) begin
      wrCount++;
      wrAddr <= arrAddr;
      wrByte <= arrWrData;
    end
    if (arrEraseStb === 1'b1) erCount++;
    if (ioOe !== 4'h0) oeSeen = 1'b1;
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      conclude();
    end
  end
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic [127:0] tx, input int nbits);
    for (int k = 0; k < 3000 && writeInProgress !== 1'b0; k++) @(posedge ref_clk);
    u_host.frame(tx, nbits, rx);
  endtask
  task automatic resetDut(input logic pwdMode);
    passwordModeSel <= pwdMode;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  function automatic logic [63:0] sw(input logic [63:0] p);
    for (int i = 0; i < 8; i++) sw[63 - 8 * i -: 8] = p[8 * i +: 8];
  endfunction
  initial begin
    rst = 1'b1; passwordModeSel = 1'b0; pwdRegionLockN = 1'b1; arrBusy = 1'b0; dummyCycles = 4'h8;
    pwd = 64'h0123456789abcdef; oeSeen = 1'b0;
    resetDut(1'b0);
    chk(persistentLockBit, 1, "lock after reset");
    chk({programErrorFlag, protectionErrorFlag, addr4Mode, writeInProgress}, 0, "flags after reset");
    cmd({`SFP_OP_READ, 24'hffffff, 16'h0}, 48);
    chk(rx[15:0], {8'hff ^ 8'h5a, 8'h5a}, "read across bank");
    chk(arrAddr, 32'h01000002, "stream address");
    cmd({`SFP_OP_READ, 24'h000010, 8'h0}, 40);
    chk(arrAddr, 32'h00000012, "bank kept");
    cmd({`SFP_OP_WRBANK, 8'h01}, 16);
    cmd({`SFP_OP_READ, 24'h000020, 8'h0}, 40);
    chk({rx[7:0], arrAddr}, {8'h7a, 32'h01000022}, "banked read");
    cmd({`SFP_OP_WRBANK, 8'h80}, 16);
    chk(addr4Mode, 1, "extended bit");
    cmd({`SFP_OP_READ, 32'h01000030, 8'h0}, 48);
    chk(arrAddr, 32'h01000032, "4-byte read");
    cmd(`SFP_OP_SRST, 8);
    chk(addr4Mode, 0, "soft reset mode");
    cmd(`SFP_OP_EN4B, 8);
    chk(addr4Mode, 1, "enter 4-byte");
    cmd(`SFP_OP_EX4B, 8);
    cmd({`SFP_OP_EN4B, 1'b0}, 9);
    chk(addr4Mode, 0, "odd frame");
    cmd({`SFP_OP_READ4, 32'h00000040, 8'h0}, 48);
    chk(arrAddr, 32'h00000042, "4-byte opcode");
    cmd({`SFP_OP_FRD, 24'h000050, 16'h0}, 48);
    chk(rx[7:0], 8'h0a, "fast read dummy");
    cmd({`SFP_OP_WRDYB, 24'h020000, 8'h00}, 40);
    cmd({`SFP_OP_PP, 24'h020005, 8'ha5}, 40);
    chk({wrCount, programErrorFlag, protectionErrorFlag}, 3, "protected program");
    cmd(`SFP_OP_CLSR, 8);
    cmd({`SFP_OP_WRDYB, 24'h020000, 8'hff}, 40);
    cmd({`SFP_OP_PP, 24'h0200fe, 16'ha53c}, 48);
    chk({wrCount[7:0], wrByte, wrAddr[23:0]}, {8'h02, 8'h3c, 24'h0200ff}, "open program");
    cmd({`SFP_OP_WRDYB, 24'h020000, 8'h00}, 40);
    cmd(`SFP_OP_SRST, 8);
    cmd({`SFP_OP_PP, 24'h020000, 8'h11}, 40);
    chk(wrCount, 3, "dynamic cleared by soft reset");
    cmd({`SFP_OP_SER, 24'h060000}, 32);
    chk({erCount[7:0], arrEraseOp}, {8'h01, `SFP_OP_SER}, "erase");
    cmd(`SFP_OP_CLRLOCK, 8);
    cmd(`SFP_OP_SRST, 8);
    chk(persistentLockBit, 0, "lock cleared and kept");
    cmd({`SFP_OP_PGPPB, 24'h050000}, 32);
    chk({programErrorFlag, protectionErrorFlag}, 3, "persistent refused");
    cmd(`SFP_OP_CLSR, 8);
    cmd({`SFP_OP_WRDYB, 24'h050000, 8'h00}, 40);
    cmd({`SFP_OP_PP, 24'h050000, 8'h11}, 40);
    chk({wrCount, protectionErrorFlag}, {32'h3, 1'b1}, "dynamic still writable");
    arrBusy <= 1'b1;
    oeSeen = 1'b0;
    u_host.frame({`SFP_OP_READ, 24'h0, 8'h0}, 40, rx);
    chk({writeInProgress, oeSeen}, 2, "read while busy");
    arrBusy <= 1'b0;
    resetDut(1'b1);
    chk(persistentLockBit, 0, "password mode lock");
    cmd({`SFP_OP_RDPWD, 64'h0}, 72);
    chk(rx[63:32] & rx[31:0], 32'hffffffff, "factory password");
    cmd({`SFP_OP_PGPWD, sw(pwd)}, 72);
    cmd({`SFP_OP_PGPWD, 64'hffffffffffffffff}, 72);
    cmd({`SFP_OP_RDPWD, 64'h0}, 72);
    chk(rx[63:32] ^ sw(pwd) >> 32, 0, "password upper");
    chk({rx[31:0] ^ sw(pwd) & 32'hffffffff, programErrorFlag}, 0, "password lower");
    cmd({`SFP_OP_UNLOCK, sw(~pwd)}, 72);
    chk({programErrorFlag, protectionErrorFlag, persistentLockBit}, 6, "wrong password");
    repeat (1500) @(posedge ref_clk);
    chk(writeInProgress, 1, "throttle held");
    repeat (1000) @(posedge ref_clk);
    chk(writeInProgress, 0, "throttle ended");
    cmd(`SFP_OP_CLSR, 8);
    cmd({`SFP_OP_UNLOCK, sw(pwd)}, 72);
    repeat (20) @(posedge ref_clk);
    chk({writeInProgress, persistentLockBit}, 1, "correct password");
    pwdRegionLockN <= 1'b0;
    cmd({`SFP_OP_PGPWD, 64'h0}, 72);
    oeSeen = 1'b0;
    cmd({`SFP_OP_RDPWD, 64'h0}, 72);
    chk(oeSeen, 0, "locked region read");
    pwdRegionLockN <= 1'b1;
    cmd({`SFP_OP_RDPWD, 64'h0}, 72);
    chk(rx[31:0], sw(pwd) & 32'hffffffff, "locked region program");
    conclude();
  end
endmodule
`default_nettype wire
